// ---- tsf_defs.vh ----
`ifndef TSF_DEFS_VH
`define TSF_DEFS_VH

// clock and timing
`define TSF_CLK_MHZ     100
`define TSF_POR_MS      20
`define TSF_TO_MS       15
`define TSF_CONV_MS     10
`define TSF_POR_CYC     (`TSF_POR_MS * 1000 * `TSF_CLK_MHZ)
`define TSF_TO_CYC      (`TSF_TO_MS * 1000 * `TSF_CLK_MHZ)
`define TSF_CONV_CYC    (`TSF_CONV_MS * 1000 * `TSF_CLK_MHZ)
`define TSF_CNT_W       22

// addressing
`define TSF_ADDR_BASE   5'h12
`define TSF_SEL_GND     2'h0
`define TSF_SEL_VCC     2'h1
`define TSF_SEL_SDA     2'h2
`define TSF_SEL_SCL     2'h3
`define TSF_GC_ADDR     8'h00
`define TSF_ARA_ADDR    7'h0C
`define TSF_GC_LATCH    8'h04
`define TSF_GC_RESET    8'h06

// mode select
`define TSF_MODE_CONT   2'h0
`define TSF_MODE_SHDN   2'h1
`define TSF_MODE_OS_BIT 1
`define TSF_MODE_RST    2'h0

// temperature result
`define TSF_TEMP_W      12
`define TSF_TEMP_RST    12'h000
`define TSF_LSB_PAD     4'h0
`define TSF_BIT_LAST    3'h7

`endif

// ---- tsf_sync.v ----
`timescale 1ns/1ps
`default_nettype none
module tsf_sync #(
  parameter W = 3
) (
  // clock and reset
  input  wire         clk_sys,
  input  wire         rst,
  // levels
  input  wire [W-1:0] d,
  output wire [W-1:0] q
);

  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      reg meta_q;
      reg sync_q;
      always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          meta_q <= 1'b1;
          sync_q <= 1'b1;
        end else begin
          meta_q <= d[i];
          sync_q <= meta_q;
        end
      end
      assign q[i] = sync_q;
    end
  endgenerate

endmodule // tsf_sync
`default_nettype wire

// ---- tsf_addr_sel.v ----
`timescale 1ns/1ps
`default_nettype none
`include "tsf_defs.vh"
module tsf_addr_sel (
  // clock and reset
  input  wire       clk_sys,
  input  wire       rst,
  // synchronised pins
  input  wire       sel_s,
  input  wire       scl_s,
  input  wire       sda_s,
  // bus events
  input  wire       start,
  input  wire       done,
  input  wire       relatch,
  input  wire       gc_rst,
  // address
  output wire [6:0] addr_cur,
  output reg  [6:0] addr_q
);

  reg valid_q;
  reg win_q;
  reg eq_scl_q;
  reg eq_sda_q;
  reg hi_q;

  // pin tied to a bus line is told apart by following that line
  function [1:0] classify;
    input eq_scl;
    input eq_sda;
    input hi;
    begin
      if (eq_scl)
        classify = `TSF_SEL_SCL;
      else if (!hi)
        classify = `TSF_SEL_GND;
      else if (eq_sda)
        classify = `TSF_SEL_SDA;
      else
        classify = `TSF_SEL_VCC;
    end
  endfunction

  assign addr_cur = valid_q ? addr_q :
    {`TSF_ADDR_BASE, classify(eq_scl_q, eq_sda_q, hi_q)};

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      valid_q  <= 1'b0;
      win_q    <= 1'b0;
      eq_scl_q <= 1'b1;
      eq_sda_q <= 1'b1;
      hi_q     <= 1'b0;
      addr_q   <= 7'h00;
    end else if (gc_rst) begin
      valid_q <= 1'b0;
      win_q   <= 1'b0;
      addr_q  <= 7'h00;
    end else if (relatch) begin
      valid_q <= 1'b0;
      win_q   <= 1'b0;
    end else if (start && !valid_q) begin
      win_q    <= 1'b1;
      eq_scl_q <= 1'b1;
      eq_sda_q <= 1'b1;
      hi_q     <= 1'b0;
    end else if (win_q) begin
      eq_scl_q <= eq_scl_q & (sel_s == scl_s);
      eq_sda_q <= eq_sda_q & (sel_s == sda_s);
      hi_q     <= hi_q | sel_s;
      if (done) begin
        // pin stops being watched once latched
        win_q   <= 1'b0;
        valid_q <= 1'b1;
        addr_q  <= addr_cur;
      end
    end
  end

endmodule // tsf_addr_sel
`default_nettype wire

// ---- tsf_target.v ----
`timescale 1ns/1ps
`default_nettype none
`include "tsf_defs.vh"
module tsf_target #(
  parameter [`TSF_CNT_W-1:0] POR_CYC  = `TSF_POR_CYC,
  parameter [`TSF_CNT_W-1:0] TO_CYC   = `TSF_TO_CYC,
  parameter [`TSF_CNT_W-1:0] CONV_CYC = `TSF_CONV_CYC
) (
  // clock and reset
  input  wire        clk_sys,
  input  wire        rst,
  // serial bus
  input  wire        scl_i,
  input  wire        sda_i,
  output reg         sda_o_q,
  output reg         sda_oe_q,
  input  wire        address_select_pin,
  // alert and in-band interrupt
  output reg         alert_o_q,
  output reg         alert_oe_q,
  input  wire        i3c_sel,
  output reg         ibi_req_q,
  output reg  [6:0]  ibi_addr_q,
  input  wire        ibi_ack,
  // converter
  output reg         conv_start_q,
  input  wire        conv_done,
  input  wire [11:0] conv_data,
  input  wire [11:0] t_high,
  input  wire [11:0] t_low,
  // status
  output reg  [11:0] temp_q,
  output reg         mode_select_high_q,
  output reg         mode_select_low_q,
  output reg         bus_ready_q
);

  localparam [6:0] S_IDLE  = 7'h01;
  localparam [6:0] S_ADDR  = 7'h02;
  localparam [6:0] S_ACK_A = 7'h04;
  localparam [6:0] S_RX    = 7'h08;
  localparam [6:0] S_ACK_R = 7'h10;
  localparam [6:0] S_TX    = 7'h20;
  localparam [6:0] S_ACK_T = 7'h40;

  localparam [1:0] K_NORM = 2'h0;
  localparam [1:0] K_GC   = 2'h1;
  localparam [1:0] K_ARA  = 2'h2;

  wire [2:0] pin_s;
  wire       scl_s = pin_s[0];
  wire       sda_s = pin_s[1];
  wire       sel_s = pin_s[2];
  wire [6:0] addr_cur;

  reg        scl_p_q;
  reg        sda_p_q;
  reg [`TSF_CNT_W-1:0] por_cnt_q;
  reg [`TSF_CNT_W-1:0] to_cnt_q;
  reg [`TSF_CNT_W-1:0] sdl_cnt_q;
  reg [`TSF_CNT_W-1:0] conv_cnt_q;
  reg [6:0]  st_q;
  reg [2:0]  bit_q;
  reg        full_q;
  reg [7:0]  sh_q;
  reg [7:0]  tx_q;
  reg        rw_q;
  reg [1:0]  kind_q;
  reg [11:0] tsnap_q;
  reg        wr_q;
  reg        relatch_q;
  reg        gcrst_q;
  reg        ara_clr_q;
  reg        os_pend_q;
  reg        busy_q;
  reg        alert_act_q;
  reg        alert_hi_q;

  // sampling at 100 MHz leaves 8 cycles per 12.5 MHz bit
  tsf_sync #(
    .W (3)
  ) u_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .d       ({address_select_pin, sda_i, scl_i}),
    .q       (pin_s)
  );

  wire scl_r = scl_s & ~scl_p_q;
  wire scl_f = ~scl_s & scl_p_q;
  wire start = scl_s & scl_p_q & sda_p_q & ~sda_s;
  wire stop  = scl_s & scl_p_q & ~sda_p_q & sda_s;
  wire to_hit = (to_cnt_q == TO_CYC - 1'b1) |
                (sdl_cnt_q == TO_CYC - 1'b1);
  wire byte_end = scl_f & full_q;
  wire addr_done = (st_q == S_ADDR) & byte_end;
  wire dir_rd = sh_q[0];

  wire m_norm = (sh_q[7:1] == addr_cur);
  wire m_gc   = (sh_q == `TSF_GC_ADDR);
  wire m_ara  = (sh_q[7:1] == `TSF_ARA_ADDR) & dir_rd &
                alert_act_q & ~i3c_sel;

  wire hi_x = $signed(conv_data) > $signed(t_high);
  wire lo_x = $signed(conv_data) < $signed(t_low);
  wire os_mode = mode_select_high_q;
  wire shdn = ~os_mode & mode_select_low_q;

  tsf_addr_sel u_addr (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .sel_s    (sel_s),
    .scl_s    (scl_s),
    .sda_s    (sda_s),
    .start    (start & bus_ready_q),
    .done     (addr_done),
    .relatch  (relatch_q),
    .gc_rst   (gcrst_q),
    .addr_cur (addr_cur),
    .addr_q   ()
  );

  // first byte of a read comes live, the second from the snapshot
  function [7:0] temp_byte;
    input       idx;
    input [11:0] t;
    begin
      if (idx)
        temp_byte = {t[3:0], `TSF_LSB_PAD};
      else
        temp_byte = t[11:4];
    end
  endfunction

  wire [7:0] nxt_byte = temp_byte(sh_q[0], tsnap_q);

  // power-on hold-off and stuck-line timeout
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      por_cnt_q   <= {`TSF_CNT_W{1'b0}};
      bus_ready_q <= 1'b0;
      to_cnt_q    <= {`TSF_CNT_W{1'b0}};
      sdl_cnt_q   <= {`TSF_CNT_W{1'b0}};
      scl_p_q     <= 1'b1;
      sda_p_q     <= 1'b1;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
      if (!bus_ready_q) begin
        por_cnt_q <= por_cnt_q + 1'b1;
        if (por_cnt_q == POR_CYC - 1'b1)
          bus_ready_q <= 1'b1;
      end
      // each line is timed alone: sda held low for TO_CYC cycles trips the timeout even while scl toggles
      if (scl_s || to_hit)
        to_cnt_q <= {`TSF_CNT_W{1'b0}};
      else
        to_cnt_q <= to_cnt_q + 1'b1;
      if (sda_s || to_hit)
        sdl_cnt_q <= {`TSF_CNT_W{1'b0}};
      else
        sdl_cnt_q <= sdl_cnt_q + 1'b1;
    end
  end

  // serial target engine; only sda is ever driven, low only
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_q      <= S_IDLE;
      bit_q     <= 3'h0;
      full_q    <= 1'b0;
      sh_q      <= 8'h00;
      tx_q      <= 8'h00;
      rw_q      <= 1'b0;
      kind_q    <= K_NORM;
      tsnap_q   <= `TSF_TEMP_RST;
      sda_oe_q  <= 1'b0;
      sda_o_q   <= 1'b0;
      wr_q      <= 1'b0;
      relatch_q <= 1'b0;
      gcrst_q   <= 1'b0;
      ara_clr_q <= 1'b0;
    end else begin
      wr_q      <= 1'b0;
      relatch_q <= 1'b0;
      gcrst_q   <= 1'b0;
      ara_clr_q <= 1'b0;
      sda_o_q   <= 1'b0;
      if (!bus_ready_q || to_hit) begin
        st_q     <= S_IDLE;
        sda_oe_q <= 1'b0;
      end else if (start) begin
        st_q     <= S_ADDR;
        bit_q    <= 3'h0;
        full_q   <= 1'b0;
        sda_oe_q <= 1'b0;
      end else if (stop) begin
        st_q     <= S_IDLE;
        sda_oe_q <= 1'b0;
      end else begin
        if (scl_r && (st_q == S_ADDR || st_q == S_RX)) begin
          sh_q  <= {sh_q[6:0], sda_s};
          bit_q <= bit_q + 1'b1;
          if (bit_q == `TSF_BIT_LAST)
            full_q <= 1'b1;
        end
        case (st_q)
          S_ADDR: begin
            if (byte_end) begin
              full_q <= 1'b0;
              rw_q   <= dir_rd;
              if (m_ara) begin
                kind_q   <= K_ARA;
                sda_oe_q <= 1'b1;
                st_q     <= S_ACK_A;
              end else if (m_norm) begin
                kind_q   <= K_NORM;
                sda_oe_q <= 1'b1;
                st_q     <= S_ACK_A;
              end else if (m_gc) begin
                kind_q   <= K_GC;
                sda_oe_q <= 1'b1;
                st_q     <= S_ACK_A;
              end else begin
                st_q <= S_IDLE;
              end
            end
          end
          S_ACK_A: begin
            if (scl_f) begin
              bit_q <= 3'h0;
              if (rw_q && kind_q == K_ARA) begin
                sda_oe_q <= ~addr_cur[6];
                tx_q     <= {addr_cur[5:0], alert_hi_q, 1'b0};
                st_q     <= S_TX;
              end else if (rw_q) begin
                tsnap_q  <= temp_q;
                sda_oe_q <= ~temp_q[11];
                tx_q     <= {temp_q[10:4], 1'b0};
                st_q     <= S_TX;
                sh_q[0]  <= 1'b1;
              end else begin
                sda_oe_q <= 1'b0;
                st_q     <= S_RX;
              end
            end
          end
          S_RX: begin
            if (byte_end) begin
              full_q   <= 1'b0;
              sda_oe_q <= 1'b1;
              st_q     <= S_ACK_R;
              if (kind_q == K_GC) begin
                relatch_q <= (sh_q == `TSF_GC_LATCH);
                gcrst_q   <= (sh_q == `TSF_GC_RESET);
              end else begin
                wr_q <= 1'b1;
              end
            end
          end
          S_ACK_R: begin
            if (scl_f) begin
              sda_oe_q <= 1'b0;
              bit_q    <= 3'h0;
              st_q     <= S_RX;
            end
          end
          S_TX: begin
            if (scl_r) begin
              bit_q <= bit_q + 1'b1;
              if (bit_q == `TSF_BIT_LAST)
                full_q <= 1'b1;
              // a released one read back low means arbitration lost
              if (!sda_oe_q && !sda_s && kind_q == K_ARA)
                st_q <= S_IDLE;
            end else if (byte_end) begin
              full_q   <= 1'b0;
              sda_oe_q <= 1'b0;
              st_q     <= S_ACK_T;
              ara_clr_q <= (kind_q == K_ARA);
            end else if (scl_f) begin
              sda_oe_q <= ~tx_q[7];
              tx_q     <= {tx_q[6:0], 1'b0};
            end
          end
          S_ACK_T: begin
            if (scl_r && (sda_s || kind_q == K_ARA)) begin
              st_q <= S_IDLE;
            end else if (scl_f) begin
              // sh_q[0] alternates the byte of the pair
              sh_q[0]  <= ~sh_q[0];
              bit_q    <= 3'h0;
              sda_oe_q <= ~nxt_byte[7];
              tx_q     <= {nxt_byte[6:0], 1'b0};
              st_q     <= S_TX;
            end
          end
          S_IDLE: begin
            sda_oe_q <= 1'b0;
          end
          default: begin
            st_q     <= S_IDLE;
            sda_oe_q <= 1'b0;
          end
        endcase
      end
    end
  end

  // mode bits and conversion pacing
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mode_select_high_q <= 1'b0;
      mode_select_low_q  <= 1'b0;
      os_pend_q    <= 1'b0;
      busy_q       <= 1'b0;
      conv_cnt_q   <= {`TSF_CNT_W{1'b0}};
      conv_start_q <= 1'b0;
      temp_q       <= `TSF_TEMP_RST;
    end else begin
      conv_start_q <= 1'b0;
      if (conv_done) begin
        busy_q <= 1'b0;
        temp_q <= conv_data;
      end
      if (gcrst_q) begin
        {mode_select_high_q, mode_select_low_q} <= `TSF_MODE_RST;
        os_pend_q  <= 1'b0;
        conv_cnt_q <= {`TSF_CNT_W{1'b0}};
        temp_q     <= `TSF_TEMP_RST;
      end else if (wr_q) begin
        {mode_select_high_q, mode_select_low_q} <= sh_q[1:0];
        os_pend_q <= sh_q[`TSF_MODE_OS_BIT];
      end else if (os_mode) begin
        if (os_pend_q && !busy_q) begin
          os_pend_q    <= 1'b0;
          busy_q       <= 1'b1;
          conv_start_q <= 1'b1;
        end
      end else if (!shdn) begin
        if (conv_cnt_q == CONV_CYC - 1'b1) begin
          conv_cnt_q <= {`TSF_CNT_W{1'b0}};
          if (!busy_q) begin
            busy_q       <= 1'b1;
            conv_start_q <= 1'b1;
          end
        end else begin
          conv_cnt_q <= conv_cnt_q + 1'b1;
        end
      end
    end
  end

  // alert flag: a new crossing wins over a clear in the same cycle
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      alert_act_q <= 1'b0;
      alert_hi_q  <= 1'b0;
      alert_oe_q  <= 1'b0;
      alert_o_q   <= 1'b0;
      ibi_req_q   <= 1'b0;
      ibi_addr_q  <= 7'h00;
    end else begin
      alert_o_q  <= 1'b0;
      ibi_addr_q <= addr_cur;
      if (conv_done && (hi_x || lo_x)) begin
        alert_act_q <= ~i3c_sel;
        alert_hi_q  <= hi_x;
      end else if (ara_clr_q || gcrst_q) begin
        alert_act_q <= 1'b0;
      end
      alert_oe_q <= alert_act_q & ~i3c_sel;
      if (conv_done && (hi_x || lo_x) && i3c_sel)
        ibi_req_q <= 1'b1;
      else if (ibi_ack || gcrst_q)
        ibi_req_q <= 1'b0;
    end
  end

endmodule // tsf_target
`default_nettype wire

// ---- dummy_end_marker_not_used.v ----
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ---- tsf_target_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "tsf_defs.vh"
module tsf_target_assertions #(
  parameter [`TSF_CNT_W-1:0] POR_CYC  = `TSF_POR_CYC,
  parameter [`TSF_CNT_W-1:0] TO_CYC   = `TSF_TO_CYC,
  parameter [`TSF_CNT_W-1:0] CONV_CYC = `TSF_CONV_CYC
) (
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        rst,
  // serial bus
  input wire logic        scl_i,
  input wire logic        sda_o_q,
  input wire logic        sda_oe_q,
  // alert and interrupt
  input wire logic        alert_oe_q,
  input wire logic        i3c_sel,
  input wire logic        ibi_req_q,
  input wire logic [6:0]  ibi_addr_q,
  // converter and status
  input wire logic        conv_start_q,
  input wire logic        conv_done,
  input wire logic [11:0] conv_data,
  input wire logic [11:0] t_high,
  input wire logic [11:0] temp_q,
  input wire logic        mode_select_high_q,
  input wire logic        mode_select_low_q,
  input wire logic        bus_ready_q
);
  logic [`TSF_CNT_W-1:0] cyc_q;
  logic [`TSF_CNT_W-1:0] gap_q;
  logic [`TSF_CNT_W-1:0] lo_q;
  wire  [1:0]            mode = {mode_select_high_q, mode_select_low_q};
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // gap only runs while continuous conversion is owed
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cyc_q <= '0;
      gap_q <= '0;
      lo_q <= '0;
    end else begin
      cyc_q <= (cyc_q == '1) ? cyc_q : cyc_q + 1'b1;
      gap_q <= (conv_start_q || mode != `TSF_MODE_CONT || !bus_ready_q) ?
               '0 : gap_q + 1'b1;
      lo_q <= scl_i ? '0 : lo_q + 1'b1;
    end
  end
  chk_sda_open_drain: assert property (sda_o_q == 1'b0)
    else $error("data output driven high");
  chk_ready_time: assert property (
    bus_ready_q |-> cyc_q >= POR_CYC - 1'b1)
    else $error("bus ready too early");
  chk_ready_rises: assert property (
    cyc_q >= POR_CYC + 2 |-> bus_ready_q)
    else $error("bus ready too late");
  chk_quiet_early: assert property (!bus_ready_q |-> !sda_oe_q)
    else $error("data line pulled during hold-off");
  chk_temp_load: assert property (
    conv_done |-> ##[1:2] temp_q == conv_data)
    else $error("result not held");
  chk_temp_hold: assert property (
    $changed(temp_q) |-> $past(conv_done) || $past(conv_done, 2) ||
    temp_q == `TSF_TEMP_RST)
    else $error("result changed without conversion");
  chk_shdn_quiet: assert property (
    mode == `TSF_MODE_SHDN && $past(mode) == `TSF_MODE_SHDN |-> !conv_start_q)
    else $error("conversion started in shutdown");
  chk_cont_period: assert property (gap_q <= CONV_CYC + 4)
    else $error("continuous conversion stalled");
  chk_alert_set: assert property (
    conv_done && !i3c_sel && $signed(conv_data) > $signed(t_high)
    |-> ##[1:3] alert_oe_q)
    else $error("alert not raised");
  chk_ibi_set: assert property (
    conv_done && i3c_sel && $signed(conv_data) > $signed(t_high)
    |-> ##[1:3] ibi_req_q)
    else $error("in-band interrupt not raised");
  chk_ibi_addr: assert property (
    ibi_req_q |-> ibi_addr_q[6:2] == `TSF_ADDR_BASE)
    else $error("interrupt address wrong");
  chk_bus_timeout: assert property (lo_q > TO_CYC + 8 |-> !sda_oe_q)
    else $error("data line held past timeout");
  cover property ($rose(alert_oe_q));
  cover property ($rose(ibi_req_q));
  cover property (lo_q == TO_CYC);
endmodule // tsf_target_assertions
bind tsf_target tsf_target_assertions #(
  .POR_CYC(POR_CYC), .TO_CYC(TO_CYC), .CONV_CYC(CONV_CYC)
) tsf_target_assertions_i (
  .clk_sys(clk_sys), .rst(rst), .scl_i(scl_i), .sda_o_q(sda_o_q),
  .sda_oe_q(sda_oe_q), .alert_oe_q(alert_oe_q), .i3c_sel(i3c_sel),
  .ibi_req_q(ibi_req_q), .ibi_addr_q(ibi_addr_q),
  .conv_start_q(conv_start_q), .conv_done(conv_done),
  .conv_data(conv_data), .t_high(t_high), .temp_q(temp_q),
  .mode_select_high_q(mode_select_high_q),
  .mode_select_low_q(mode_select_low_q), .bus_ready_q(bus_ready_q));
`default_nettype wire

// ---- tsf_ctl_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module tsf_ctl_model #(
  parameter int HALF = 8
) (
  // clock
  input  wire logic clk_sys,
  // bus lines
  input  wire logic sda,
  output var logic  scl,
  output var logic  sda_low
);
  // clock idles high between frames, never free-running
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic hc();
    repeat (HALF) @(posedge clk_sys);
  endtask
  task automatic start();
    sda_low <= 1'b0;
    hc();
    scl <= 1'b1;
    hc();
    sda_low <= 1'b1;
    hc();
    scl <= 1'b0;
    hc();
  endtask
  task automatic stop();
    sda_low <= 1'b1;
    hc();
    scl <= 1'b1;
    hc();
    sda_low <= 1'b0;
    hc();
  endtask
  // data only moves while clock is low; sampled at the high phase end
  task automatic bit1(input logic b, output logic r);
    sda_low <= ~b;
    hc();
    scl <= 1'b1;
    hc();
    r = sda;
    scl <= 1'b0;
    hc();
  endtask
  task automatic byte8(input logic [7:0] w, input logic a,
                       output logic [7:0] r, output logic s);
    for (int i = 7; i >= 0; i--) bit1(w[i], r[i]);
    bit1(a, s);
  endtask
endmodule // tsf_ctl_model
`default_nettype wire

// ---- tsf_target_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "tsf_defs.vh"
module tsf_target_tb;
  localparam [`TSF_CNT_W-1:0] TOC = 22'd500;
  localparam [11:0] TEMP  = 12'h3A7;
  localparam [6:0]  A_SCL = {`TSF_ADDR_BASE, `TSF_SEL_SCL};
  localparam [6:0]  A_GND = {`TSF_ADDR_BASE, `TSF_SEL_GND};
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic        i3c_sel = 1'b0;
  logic        ibi_ack = 1'b0;
  logic        conv_done = 1'b0;
  logic [11:0] t_high = 12'h7FF;
  logic [11:0] t_low = 12'h800;
  logic [1:0]  pin_sel = `TSF_SEL_SCL;
  int          n_errors = 0;
  int          n_compared = 0;
  int          n_starts = 0;
  wire         sda_o_q, sda_oe_q, alert_o_q, alert_oe_q, ibi_req_q;
  wire         conv_start_q, mode_select_high_q, mode_select_low_q;
  wire         bus_ready_q, scl_w, sda_low, sda_w, address_select_pin;
  wire [6:0]   ibi_addr_q;
  wire [11:0]  temp_q;
  wire [11:0]  mode_w = {10'h0, mode_select_high_q, mode_select_low_q};
  // pull-up on the data line; only low drives win
  assign sda_w = ~((sda_oe_q & ~sda_o_q) | sda_low);
  assign address_select_pin = pin_sel == `TSF_SEL_GND ? 1'b0 :
    pin_sel == `TSF_SEL_VCC ? 1'b1 : pin_sel == `TSF_SEL_SDA ? sda_w : scl_w;
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    conv_done <= conv_start_q;
    if (conv_start_q) n_starts <= n_starts + 1;
  end
  tsf_target #(.POR_CYC(22'd50), .TO_CYC(TOC), .CONV_CYC(22'd100))
  tsf_target_i (
    .clk_sys(clk_sys), .rst(rst), .scl_i(scl_w), .sda_i(sda_w),
    .sda_o_q(sda_o_q), .sda_oe_q(sda_oe_q),
    .address_select_pin(address_select_pin), .alert_o_q(alert_o_q),
    .alert_oe_q(alert_oe_q), .i3c_sel(i3c_sel), .ibi_req_q(ibi_req_q),
    .ibi_addr_q(ibi_addr_q), .ibi_ack(ibi_ack),
    .conv_start_q(conv_start_q), .conv_done(conv_done), .conv_data(TEMP),
    .t_high(t_high), .t_low(t_low), .temp_q(temp_q),
    .mode_select_high_q(mode_select_high_q),
    .mode_select_low_q(mode_select_low_q), .bus_ready_q(bus_ready_q));
  tsf_ctl_model tsf_ctl_model_i (
    .clk_sys(clk_sys), .sda(sda_w), .scl(scl_w), .sda_low(sda_low));
  task automatic chk(input string what, input logic [11:0] e, g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic open_frame(input logic [6:0] a, input logic rd,
                            output logic ack);
    logic [7:0] r;
    logic s;
    tsf_ctl_model_i.start();
    tsf_ctl_model_i.byte8({a, rd}, 1'b1, r, s);
    ack = ~s;
  endtask
  task automatic write1(input logic [6:0] a, input logic [7:0] d);
    logic ack;
    logic [7:0] r;
    logic s;
    open_frame(a, 1'b0, ack);
    tsf_ctl_model_i.byte8(d, 1'b1, r, s);
    tsf_ctl_model_i.stop();
    chk("write acks", 12'h3, {10'h0, ack, ~s});
  endtask
  task automatic read1(input logic [6:0] a, output logic [7:0] b);
    logic ack;
    logic s;
    open_frame(a, 1'b1, ack);
    tsf_ctl_model_i.byte8(8'hFF, 1'b1, b, s);
    tsf_ctl_model_i.stop();
    chk("read ack", 12'h1, {11'h0, ack});
  endtask
  task automatic t_read();
    logic ack;
    logic s;
    logic [7:0] b0, b1;
    for (int i = 0; i < 300 && temp_q !== TEMP; i++) @(posedge clk_sys);
    open_frame(A_SCL, 1'b1, ack);
    tsf_ctl_model_i.byte8(8'hFF, 1'b0, b0, s);
    tsf_ctl_model_i.byte8(8'hFF, 1'b1, b1, s);
    tsf_ctl_model_i.stop();
    chk("ack on pin at clock", 12'h1, {11'h0, ack});
    chk("result high byte", {4'h0, TEMP[11:4]}, {4'h0, b0});
    chk("result low byte", {TEMP[3:0], 8'h0}, {b1, 4'h0});
    pin_sel <= `TSF_SEL_GND;
    open_frame(A_GND, 1'b0, ack);
    tsf_ctl_model_i.stop();
    chk("pin not resampled", 12'h0, {11'h0, ack});
    write1(A_SCL, 8'h00);
  endtask
  task automatic t_modes();
    int n;
    write1(A_SCL, 8'h01);
    chk("mode shutdown", 12'h1, mode_w);
    n = n_starts;
    repeat (300) @(posedge clk_sys);
    chk("starts in shutdown", 12'h0, 12'(n_starts - n));
    write1(A_SCL, 8'h02);
    repeat (300) @(posedge clk_sys);
    chk("one-shot starts", 12'h1, 12'(n_starts - n));
    n = n_starts;
    write1(A_SCL, 8'h00);
    repeat (300) @(posedge clk_sys);
    chk("periodic starts", 12'h1, {11'h0, n_starts - n >= 2});
  endtask
  task automatic t_alert();
    logic [7:0] b;
    t_high <= 12'h800;
    for (int i = 0; i < 300 && alert_oe_q !== 1'b1; i++) @(posedge clk_sys);
    chk("alert on signed limit", 12'h1, {11'h0, alert_oe_q});
    chk("alert pin only pulls low", 12'h0, {11'h0, alert_o_q});
    write1(A_SCL, 8'h01);
    read1(`TSF_ARA_ADDR, b);
    chk("response high", {4'h0, A_SCL, 1'b1}, {4'h0, b});
    repeat (4) @(posedge clk_sys);
    chk("alert cleared", 12'h0, {11'h0, alert_oe_q});
    t_high <= 12'h7FF;
    t_low <= 12'h400;
    write1(A_SCL, 8'h02);
    for (int i = 0; i < 300 && alert_oe_q !== 1'b1; i++) @(posedge clk_sys);
    read1(`TSF_ARA_ADDR, b);
    chk("response low", {4'h0, A_SCL, 1'b0}, {4'h0, b});
    t_low <= 12'h800;
    i3c_sel <= 1'b1;
    t_high <= 12'h800;
    write1(A_SCL, 8'h02);
    for (int i = 0; i < 300 && ibi_req_q !== 1'b1; i++) @(posedge clk_sys);
    chk("ibi address", {5'h0, A_SCL}, {5'h0, ibi_addr_q});
    chk("no pin alert on i3c", 12'h0, {11'h0, alert_oe_q});
    ibi_ack <= 1'b1;
    @(posedge clk_sys);
    ibi_ack <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk("ibi cleared", 12'h0, {11'h0, ibi_req_q});
    i3c_sel <= 1'b0;
    t_high <= 12'h7FF;
  endtask
  task automatic t_gcall_timeout();
    logic ack;
    write1(A_SCL, 8'h01);
    write1(7'h00, `TSF_GC_LATCH);
    write1(A_GND, 8'h01);
    write1(7'h00, `TSF_GC_RESET);
    chk("mode after reset call", {10'h0, `TSF_MODE_RST}, mode_w);
    open_frame(A_GND, 1'b1, ack);
    chk("ack after reset call", 12'h1, {11'h0, ack});
    chk("first bit driven", 12'h1, {11'h0, sda_oe_q});
    repeat (TOC + 20) @(posedge clk_sys);
    chk("released on timeout", 12'h0, {11'h0, sda_oe_q});
    tsf_ctl_model_i.stop();
    write1(A_GND, 8'h00);
  endtask
  task automatic tally_and_finish();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk_sys);
    chk("result in reset", `TSF_TEMP_RST, temp_q);
    chk("mode in reset", {10'h0, `TSF_MODE_RST}, mode_w);
    rst <= 1'b0;
    for (int i = 0; i < 70 && bus_ready_q !== 1'b1; i++) @(posedge clk_sys);
    chk("bus ready", 12'h1, {11'h0, bus_ready_q});
    repeat (3) @(posedge clk_sys);
    t_read();
    t_modes();
    t_alert();
    t_gcall_timeout();
    tally_and_finish();
  end
  initial begin
    repeat (30000) @(posedge clk_sys);
    n_errors++;
    tally_and_finish();
  end
endmodule // tsf_target_tb
`default_nettype wire
